/* File: pkg/test_page_pkg.sv */
// Constants, types and field layouts shared by the test page logic.
package test_page_pkg;

	// -----------------------------------------------------------------
	// Register offsets
	// -----------------------------------------------------------------
	localparam logic [5:0] OFS_PAGE_SELECT_CONTROL = 6'h30;
	localparam logic [5:0] OFS_TEST_SIGNAL_SELECT_ONE = 6'h31;
	localparam logic [5:0] OFS_PROBE_BUS_AND_SEQUENCE_CONTROL = 6'h32;
	localparam logic [5:0] OFS_PIN_DRIVER_ENABLE = 6'h33;
	localparam logic [5:0] OFS_PIN_OUTPUT_VALUE = 6'h34;

	// -----------------------------------------------------------------
	// Reset values
	// -----------------------------------------------------------------
	localparam logic [7:0] RST_PAGE_SELECT_CONTROL = 8'h00;
	localparam logic [7:0] RST_TEST_SIGNAL_SELECT_ONE = 8'h00;
	localparam logic [7:0] RST_PROBE_BUS_AND_SEQUENCE_CONTROL = 8'h00;
	localparam logic [7:0] RST_PIN_DRIVER_ENABLE = 8'h80;
	localparam logic [7:0] RST_PIN_OUTPUT_VALUE = 8'h00;

	// -----------------------------------------------------------------
	// Field positions
	// -----------------------------------------------------------------
	localparam int POS_PAGE_NUMBER_ENABLE = 7;
	localparam int POS_PAGE_NUMBER_LSB = 0;
	localparam int POS_SECURE_CLOCK_SOURCE_LSB = 4;
	localparam int POS_SECURE_CLOCK_ON_D1 = 3;
	localparam int POS_PROBE_BIT_SELECT_LSB = 0;
	localparam int POS_PROBE_BUS_REORDER = 7;
	localparam int POS_PRBS9_ENABLE = 6;
	localparam int POS_PRBS15_ENABLE = 5;
	localparam int POS_PROBE_BUS_SELECT_LSB = 0;
	localparam int POS_UART_AUX_LINES_ENABLE = 7;
	localparam int POS_PARALLEL_PINS_AS_IO = 7;
	localparam int LOW_ADDR_BITS = 4;
	localparam int DATA_PINS = 7;

	// Mask of pins usable as general I/O when D5 and D6 are taken.
	localparam logic [6:0] NARROW_PIN_MASK = 7'h1F;

	// -----------------------------------------------------------------
	// Enumerations
	// -----------------------------------------------------------------
	typedef enum logic [1:0] {
		HOST_PARALLEL = 2'b00,
		HOST_SPI = 2'b01,
		HOST_UART = 2'b10,
		HOST_I2C = 2'b11
	} host_if_t;

	typedef enum logic [1:0] {
		CLK_SRC_OFF = 2'b00,
		CLK_SRC_OSC = 2'b01,
		CLK_SRC_UART = 2'b10,
		CLK_SRC_RF = 2'b11
	} clock_source_t;

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_ARMED = 2'b01,
		SEQ_SEND = 2'b10
	} seq_state_t;

	// -----------------------------------------------------------------
	// Carriers
	// -----------------------------------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic [5:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic [6:0] value;
		logic [6:0] enable;
	} pin_drive_t;

endpackage

/* File: hdl/test_page_control.sv */
// Test register page: address paging, clock routing, probes, PRBS, pins.
`timescale 1ns/1ps
// What this block does
// [RULE1] Page enable set: page number becomes address bits A5 and A4.
// [RULE2] Page enable clear: whole address comes from the internal latch.
// [RULE3] Page number field is ignored unless page enable bit 7 is set.
// [RULE4] Secure clock source: 00 off, 01 oscillator, 10 UART, 11 RF.
// [RULE5] Bit 3 puts secure clock on D1, only without parallel host.
// [RULE6] Bits 2 to 0 pick the probe bit sent to the signal output.
// [RULE7] Reorder bit drives probe bus on D4,D3,D2,D6,D5,D0,D1.
// [RULE8] Bit 6 enables PRBS9; sending starts only at the send command.
// [RULE9] Bit 5 enables PRBS15; sending starts only at the send command.
// [RULE10] Host configures transmit registers before setting a PRBS bit.
// [RULE11] Bits 4 to 0 select which internal probe bus is observed.
// [RULE12] Pin enable bit 7 clear disables UART mode and request lines.
// [RULE13] Each set bit n of bits 6 to 0 enables driver of Dn.
// [RULE14] Per-pin enables act only with a serial host interface.
// [RULE15] With SPI, or UART with aux lines, only D0 to D4 serve.
// [RULE16] Pins are general I/O only with I/O bit set and serial host.
// [RULE17] Reserved page bits 6 to 2 read zero and ignore writes.
module test_page_control
	import test_page_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Register access from the host interface
	input wire test_page_pkg::reg_req_t req,
	output logic [7:0] rdata_q,
	output logic rvalid_q,
	// Host address path
	input wire test_page_pkg::host_if_t host_if,
	input wire logic [5:0] addr_latch,
	input wire logic [3:0] addr_low,
	output logic [5:0] reg_addr_q,
	output logic addr_pins_detect_q,
	// Secure-module clock sources, asynchronous to clk_sys
	input wire logic osc_clk,
	input wire logic uart_clk,
	input wire logic rf_clk,
	output logic secure_clock_q,
	// Probe bus
	input wire logic [7:0] probe_data,
	output logic [4:0] probe_bus_select_q,
	output logic signal_output_pin_q,
	// Pseudo-random transmit
	input wire logic send_cmd,
	output logic prbs_active_q,
	output logic prbs_bit_q,
	// UART auxiliary lines
	output logic uart_aux_lines_enable_q,
	// Parallel data pins D6..D0
	input wire logic [6:0] d_in,
	output logic [6:0] d_out_q,
	output logic [6:0] d_oe_q
);
	import test_page_pkg::*;

	// -----------------------------------------------------------------
	// Registers
	// -----------------------------------------------------------------
	logic page_number_enable_q;
	logic [1:0] page_number_q;
	logic [7:0] test_sel_one_q;
	logic [7:0] test_sel_two_q;
	logic [7:0] pin_enable_q;
	logic [7:0] pin_value_q;

	logic serial_host;
	logic [1:0] secure_clock_source;
	logic secure_clock_on_d1;
	logic [2:0] probe_bit_select;
	logic probe_bus_reorder;
	logic prbs9_enable;
	logic prbs15_enable;
	logic uart_aux_lines_enable;
	logic [6:0] pin_driver_enables;
	logic parallel_pins_as_io;
	logic [6:0] pin_output_values;

	assign serial_host = (host_if != HOST_PARALLEL);
	assign secure_clock_source =
		test_sel_one_q[POS_SECURE_CLOCK_SOURCE_LSB +: 2];
	assign secure_clock_on_d1 = test_sel_one_q[POS_SECURE_CLOCK_ON_D1];
	assign probe_bit_select = test_sel_one_q[POS_PROBE_BIT_SELECT_LSB +: 3];
	assign probe_bus_reorder = test_sel_two_q[POS_PROBE_BUS_REORDER];
	assign prbs9_enable = test_sel_two_q[POS_PRBS9_ENABLE];
	assign prbs15_enable = test_sel_two_q[POS_PRBS15_ENABLE];
	assign uart_aux_lines_enable = pin_enable_q[POS_UART_AUX_LINES_ENABLE];
	assign pin_driver_enables = pin_enable_q[DATA_PINS-1:0];
	assign parallel_pins_as_io = pin_value_q[POS_PARALLEL_PINS_AS_IO];
	assign pin_output_values = pin_value_q[DATA_PINS-1:0];

	// -----------------------------------------------------------------
	// Input synchronisers
	// -----------------------------------------------------------------
	logic [2:0] clk_meta_q;
	logic [2:0] clk_sync_q;
	logic [6:0] d_meta_q;
	logic [6:0] d_sync_q;

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			clk_meta_q <= 3'h0;
			clk_sync_q <= 3'h0;
			d_meta_q <= 7'h00;
			d_sync_q <= 7'h00;
		end else begin
			clk_meta_q <= {rf_clk, uart_clk, osc_clk};
			clk_sync_q <= clk_meta_q;
			d_meta_q <= d_in;
			d_sync_q <= d_meta_q;
		end
	end

	// -----------------------------------------------------------------
	// Register writes
	// -----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			page_number_enable_q <= RST_PAGE_SELECT_CONTROL[7];
			page_number_q <= RST_PAGE_SELECT_CONTROL[1:0];
			test_sel_one_q <= RST_TEST_SIGNAL_SELECT_ONE;
			test_sel_two_q <= RST_PROBE_BUS_AND_SEQUENCE_CONTROL;
			pin_enable_q <= RST_PIN_DRIVER_ENABLE;
			pin_value_q <= RST_PIN_OUTPUT_VALUE;
		end else if (req.wr) begin
			case (req.addr)
				OFS_PAGE_SELECT_CONTROL: begin
					// Bits 6 to 2 have no storage. see [RULE17]
					page_number_enable_q <=
						req.wdata[POS_PAGE_NUMBER_ENABLE];
					page_number_q <= req.wdata[POS_PAGE_NUMBER_LSB +: 2];
				end
				OFS_TEST_SIGNAL_SELECT_ONE: begin
					test_sel_one_q <= req.wdata;
				end
				OFS_PROBE_BUS_AND_SEQUENCE_CONTROL: begin
					test_sel_two_q <= req.wdata;
				end
				OFS_PIN_DRIVER_ENABLE: begin
					pin_enable_q <= req.wdata;
				end
				OFS_PIN_OUTPUT_VALUE: begin
					pin_value_q <= req.wdata;
				end
				default: begin
				end
			endcase
		end
	end

	// -----------------------------------------------------------------
	// Register reads
	// -----------------------------------------------------------------
	function automatic logic [7:0] read_mux(input logic [5:0] a);
		logic [7:0] v;
		v = 8'h00;
		case (a)
			OFS_PAGE_SELECT_CONTROL: begin
				v = {page_number_enable_q, 5'h00, page_number_q}; // see [RULE17]
			end
			OFS_TEST_SIGNAL_SELECT_ONE: begin
				v = test_sel_one_q;
			end
			OFS_PROBE_BUS_AND_SEQUENCE_CONTROL: begin
				v = test_sel_two_q;
			end
			OFS_PIN_DRIVER_ENABLE: begin
				v = pin_enable_q;
			end
			OFS_PIN_OUTPUT_VALUE: begin
				// In I/O use the live pin levels are returned instead.
				v = parallel_pins_as_io ?
					{1'b1, d_sync_q} : pin_value_q;
			end
			default: begin
				v = 8'h00;
			end
		endcase
		return v;
	endfunction

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rdata_q <= 8'h00;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= req.rd;
			if (req.rd) begin
				rdata_q <= read_mux(req.addr);
			end
		end
	end

	// -----------------------------------------------------------------
	// Address paging
	// -----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			reg_addr_q <= 6'h00;
			addr_pins_detect_q <= 1'b1;
		end else if (page_number_enable_q) begin
			// Page number forms the address only in this branch. see [RULE3]
			reg_addr_q <= {page_number_q, addr_low}; // see [RULE1]
			addr_pins_detect_q <= 1'b0;
		end else begin
			reg_addr_q <= addr_latch; // see [RULE2]
			addr_pins_detect_q <= 1'b1;
		end
	end

	// -----------------------------------------------------------------
	// Secure-module clock
	// -----------------------------------------------------------------
	// The sampled source is only as good as clk_sys allows; a true
	// 13.56 MHz path would use a glitch-free clock mux instead.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			secure_clock_q <= 1'b0;
		end else begin
			case (clock_source_t'(secure_clock_source)) // see [RULE4]
				CLK_SRC_OFF: secure_clock_q <= 1'b0;
				CLK_SRC_OSC: secure_clock_q <= clk_sync_q[0];
				CLK_SRC_UART: secure_clock_q <= clk_sync_q[1];
				CLK_SRC_RF: secure_clock_q <= clk_sync_q[2];
				default: secure_clock_q <= 1'b0;
			endcase
		end
	end

	// -----------------------------------------------------------------
	// Probe bus
	// -----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			probe_bus_select_q <= 5'h00;
			signal_output_pin_q <= 1'b0;
		end else begin
			probe_bus_select_q <=
				test_sel_two_q[POS_PROBE_BUS_SELECT_LSB +: 5]; // see [RULE11]
			signal_output_pin_q <= probe_data[probe_bit_select]; // see [RULE6]
		end
	end

	// -----------------------------------------------------------------
	// Pseudo-random sequence
	// -----------------------------------------------------------------
	seq_state_t seq_q;
	logic [14:0] lfsr_q;
	logic prbs_any;

	assign prbs_any = prbs9_enable | prbs15_enable;

	function automatic logic [14:0] lfsr_step(input logic [14:0] s,
			input logic use15);
		logic fb;
		fb = use15 ? (s[14] ^ s[13]) : (s[8] ^ s[4]);
		return use15 ? {s[13:0], fb} : {6'h00, s[7:0], fb};
	endfunction

	// Clearing both enables returns to idle at once; the host is
	// trusted to have set up the transmitter first. see [RULE10]
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			seq_q <= SEQ_IDLE;
			lfsr_q <= 15'h7FFF;
			prbs_active_q <= 1'b0;
			prbs_bit_q <= 1'b0;
		end else begin
			case (seq_q)
				SEQ_IDLE: begin
					prbs_active_q <= 1'b0;
					prbs_bit_q <= 1'b0;
					lfsr_q <= 15'h7FFF;
					if (prbs_any) begin
						seq_q <= SEQ_ARMED;
					end
				end
				SEQ_ARMED: begin
					if (!prbs_any) begin
						seq_q <= SEQ_IDLE;
					end else if (send_cmd) begin
						seq_q <= SEQ_SEND; // see [RULE8] see [RULE9]
						prbs_active_q <= 1'b1;
					end
				end
				SEQ_SEND: begin
					if (!prbs_any) begin
						seq_q <= SEQ_IDLE;
						prbs_active_q <= 1'b0;
						prbs_bit_q <= 1'b0;
					end else begin
						lfsr_q <= lfsr_step(lfsr_q, prbs15_enable);
						prbs_bit_q <= prbs15_enable ?
							lfsr_q[14] : lfsr_q[8];
					end
				end
				default: begin
					seq_q <= SEQ_IDLE;
				end
			endcase
		end
	end

	// -----------------------------------------------------------------
	// Parallel data pins
	// -----------------------------------------------------------------
	logic narrow_pins;
	pin_drive_t drive;

	assign narrow_pins = (host_if == HOST_SPI) ||
		((host_if == HOST_UART) && uart_aux_lines_enable); // see [RULE15]

	always_comb begin
		drive.value = 7'h00;
		drive.enable = 7'h00;
		if (serial_host) begin // see [RULE14]
			if (probe_bus_reorder) begin
				// Probe bits 0..6 go to D4,D3,D2,D6,D5,D0,D1. see [RULE7]
				drive.value = {probe_data[3], probe_data[4],
					probe_data[0], probe_data[1], probe_data[2],
					probe_data[6], probe_data[5]};
				drive.enable = 7'h7F;
			end else if (parallel_pins_as_io) begin // see [RULE16]
				drive.value = pin_output_values;
				drive.enable = pin_driver_enables; // see [RULE13]
				// The narrow limit is on general pin use; the probe view
				// above keeps all seven drivers.
				if (narrow_pins) begin
					drive.enable = drive.enable & NARROW_PIN_MASK;
				end
			end
			if (secure_clock_on_d1) begin // see [RULE5]
				drive.value[1] = secure_clock_q;
				drive.enable[1] = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			d_out_q <= 7'h00;
			d_oe_q <= 7'h00;
			uart_aux_lines_enable_q <= RST_PIN_DRIVER_ENABLE[7];
		end else begin
			d_out_q <= drive.value;
			d_oe_q <= drive.enable;
			uart_aux_lines_enable_q <= uart_aux_lines_enable; // see [RULE12]
		end
	end

endmodule

/* File: dv/test_page_chk.sv */
// Assertion checker for the test page control block.
`timescale 1ns/1ps
module test_page_chk
	import test_page_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Watched ports
	input wire test_page_pkg::reg_req_t req,
	input wire logic [7:0] rdata_q,
	input wire logic rvalid_q,
	input wire test_page_pkg::host_if_t host_if,
	input wire logic [5:0] addr_latch,
	input wire logic [3:0] addr_low,
	input wire logic [5:0] reg_addr_q,
	input wire logic secure_clock_q,
	input wire logic [7:0] probe_data,
	input wire logic [4:0] probe_bus_select_q,
	input wire logic signal_output_pin_q,
	input wire logic send_cmd,
	input wire logic prbs_active_q,
	input wire logic uart_aux_lines_enable_q,
	input wire logic [6:0] d_oe_q
);
	logic [7:0] pg_q, sel1_q, sel2_q, pen_q, pval_q;
	logic serial, narrow, bit_exp, seq_on;
	logic [6:0] oe_exp;
	logic [5:0] addr_exp;
	logic [4:0] bus_exp;

	// Shadow copies of the registers, kept from the host writes.
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pg_q <= RST_PAGE_SELECT_CONTROL;
			sel1_q <= RST_TEST_SIGNAL_SELECT_ONE;
			sel2_q <= RST_PROBE_BUS_AND_SEQUENCE_CONTROL;
			pen_q <= RST_PIN_DRIVER_ENABLE;
			pval_q <= RST_PIN_OUTPUT_VALUE;
		end else if (req.wr) begin
			case (req.addr)
			OFS_PAGE_SELECT_CONTROL: pg_q <= req.wdata & 8'h83;
			OFS_TEST_SIGNAL_SELECT_ONE: sel1_q <= req.wdata;
			OFS_PROBE_BUS_AND_SEQUENCE_CONTROL: sel2_q <= req.wdata;
			OFS_PIN_DRIVER_ENABLE: pen_q <= req.wdata;
			OFS_PIN_OUTPUT_VALUE: pval_q <= req.wdata;
			default: ;
			endcase
		end
	end

	always_comb begin
		serial = host_if != HOST_PARALLEL;
		narrow = host_if == HOST_SPI || (host_if == HOST_UART && pen_q[7]);
		oe_exp = 7'h00;
		if (serial && sel2_q[7])
			oe_exp = 7'h7F;
		else if (serial && pval_q[7])
			oe_exp = pen_q[6:0] & (narrow ? NARROW_PIN_MASK : 7'h7F);
		if (serial && sel1_q[3])
			oe_exp[1] = 1'b1;
		addr_exp = pg_q[7] ? {pg_q[1:0], addr_low} : addr_latch;
		bit_exp = probe_data[sel1_q[2:0]];
		bus_exp = sel2_q[4:0];
		seq_on = sel2_q[6] | sel2_q[5];
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	sequence s_src_off;
		sel1_q[5:4] == 2'b00 [*6];
	endsequence
	sequence s_read_page;
		req.rd && req.addr == OFS_PAGE_SELECT_CONTROL;
	endsequence

	a_page_addr: assert property (
		!$past(reset) |-> reg_addr_q == $past(addr_exp))
		else $error("formed address wrong");
	a_pin_enables: assert property (
		!$past(reset) |-> d_oe_q == $past(oe_exp))
		else $error("pin driver enables wrong");
	a_aux_lines: assert property (
		!$past(reset) |-> uart_aux_lines_enable_q == $past(pen_q[7]))
		else $error("uart aux line enable wrong");
	a_probe_bit: assert property (
		!$past(reset) |-> signal_output_pin_q == $past(bit_exp))
		else $error("signal output bit wrong");
	a_bus_select: assert property (
		!$past(reset) |-> probe_bus_select_q == $past(bus_exp))
		else $error("probe bus select wrong");
	a_prbs_start: assert property (
		$rose(prbs_active_q) |-> $past(send_cmd) && $past(seq_on))
		else $error("sequence began without command");
	a_prbs_stop: assert property (
		!seq_on [*2] |-> !prbs_active_q)
		else $error("sequence kept running");
	a_clock_off: assert property (
		s_src_off |-> !secure_clock_q)
		else $error("secure clock runs while off");
	a_page_read: assert property (
		s_read_page |=> rvalid_q && rdata_q[6:2] == 5'h00)
		else $error("page read wrong");
endmodule

bind test_page_control test_page_chk u_chk (.clk_sys(clk_sys),
	.reset(reset), .req(req), .rdata_q(rdata_q), .rvalid_q(rvalid_q),
	.host_if(host_if), .addr_latch(addr_latch), .addr_low(addr_low),
	.reg_addr_q(reg_addr_q), .secure_clock_q(secure_clock_q),
	.probe_data(probe_data), .probe_bus_select_q(probe_bus_select_q),
	.signal_output_pin_q(signal_output_pin_q), .send_cmd(send_cmd),
	.prbs_active_q(prbs_active_q), .d_oe_q(d_oe_q),
	.uart_aux_lines_enable_q(uart_aux_lines_enable_q));

/* File: dv/host_model.sv */
// Host microcontroller model driving the register access port.
`timescale 1ns/1ps
module host_model
	import test_page_pkg::*;
(
	// Clock
	input wire logic clk_sys,
	// Register access
	output test_page_pkg::reg_req_t req,
	input wire logic [7:0] rdata_q,
	input wire logic rvalid_q,
	// Command
	output logic send_cmd
);
	initial begin
		req = '0;
		send_cmd = 1'b0;
	end
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		req <= {1'b1, 1'b0, a, d};
		@(posedge clk_sys);
		req <= '0;
	endtask
	task automatic rd(input logic [5:0] a, output logic [8:0] v);
		@(posedge clk_sys);
		req <= {1'b0, 1'b1, a, 8'h00};
		@(posedge clk_sys);
		req <= '0;
		#1;
		v = {rvalid_q, rdata_q};
	endtask
	task automatic pulse();
		@(posedge clk_sys);
		send_cmd <= 1'b1;
		@(posedge clk_sys);
		send_cmd <= 1'b0;
	endtask
	// The sequence bit is written last so the setup is complete first.
	task automatic seq(input logic [7:0] m);
		wr(OFS_PROBE_BUS_AND_SEQUENCE_CONTROL, m);
		repeat (2) @(posedge clk_sys);
		pulse();
	endtask
endmodule

/* File: dv/test_page_control_test.sv */
// Self-checking testbench for the test page control block.
`timescale 1ns/1ps
module test_page_control_test;
	import test_page_pkg::*;
	logic clk_sys = 1'b0, reset = 1'b1, osc_clk = 1'b0, uart_clk = 1'b0;
	logic rf_clk = 1'b0, send_cmd, rvalid_q, sig_q, act_q, bit_q, aux_q;
	logic det_q;
	logic [2:0] run = 3'b000;
	host_if_t host_if = HOST_PARALLEL;
	reg_req_t req;
	logic [7:0] rdata_q, probe_data = 8'h08;
	logic [5:0] addr_latch = 6'h2A, reg_addr_q;
	logic [3:0] addr_low = 4'h5;
	logic [4:0] bus_q;
	logic [6:0] ext_q = 7'h55, d_out_q, d_oe_q, pins;
	logic [8:0] v;
	logic sc_q, seen;
	logic [31:0] ref_b;
	int fails = 0, compares = 0, cycles = 0, ones;
	logic [21:0] rows [6] = '{{6'h30, 8'hFF, 8'h83}, {6'h31, 8'hA5, 8'hA5},
		{6'h32, 8'h1F, 8'h1F}, {6'h33, 8'h7F, 8'h7F},
		{6'h34, 8'h05, 8'h05}, {6'h35, 8'hFF, 8'h00}};
	logic [7:0] rst [5] = '{RST_PAGE_SELECT_CONTROL,
		RST_TEST_SIGNAL_SELECT_ONE, RST_PROBE_BUS_AND_SEQUENCE_CONTROL,
		RST_PIN_DRIVER_ENABLE, RST_PIN_OUTPUT_VALUE};
	host_if_t hm [5] = '{HOST_SPI, HOST_UART, HOST_UART, HOST_I2C,
		HOST_PARALLEL};
	logic [7:0] pe [5] = '{8'hFF, 8'hFF, 8'h7F, 8'h61, 8'h7F};
	logic [6:0] oe [5] = '{7'h1F, 7'h1F, 7'h7F, 7'h61, 7'h00};
	logic [7:0] pm [2] = '{8'h40, 8'h20};

	initial forever #12.5 clk_sys = ~clk_sys;
	// Stopped sources rest low so a wrong selection shows no edges.
	always #60 osc_clk = run[0] ? ~osc_clk : 1'b0;
	always #70 uart_clk = run[1] ? ~uart_clk : 1'b0;
	always #80 rf_clk = run[2] ? ~rf_clk : 1'b0;
	assign pins = (d_oe_q & d_out_q) | (~d_oe_q & ext_q);

	host_model h (.clk_sys(clk_sys), .req(req), .rdata_q(rdata_q),
		.rvalid_q(rvalid_q), .send_cmd(send_cmd));
	test_page_control uut (.clk_sys(clk_sys), .reset(reset), .req(req),
		.rdata_q(rdata_q), .rvalid_q(rvalid_q), .host_if(host_if),
		.addr_latch(addr_latch), .addr_low(addr_low),
		.reg_addr_q(reg_addr_q), .addr_pins_detect_q(det_q),
		.osc_clk(osc_clk), .uart_clk(uart_clk), .rf_clk(rf_clk),
		.secure_clock_q(sc_q), .probe_data(probe_data),
		.probe_bus_select_q(bus_q), .signal_output_pin_q(sig_q),
		.send_cmd(send_cmd), .prbs_active_q(act_q), .prbs_bit_q(bit_q),
		.uart_aux_lines_enable_q(aux_q), .d_in(pins), .d_out_q(d_out_q),
		.d_oe_q(d_oe_q));

	task automatic check(input logic [8:0] seen_v, input logic [8:0] exp);
		compares++;
		if (seen_v !== exp) begin
			fails++;
			$display("mismatch at %0t: saw %h want %h", $time, seen_v, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic give_verdict();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 8000) begin
			fails++;
			give_verdict();
		end
	end

	initial begin
		repeat (20) @(posedge clk_sys);
		reset <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			h.rd(6'h30 + 6'(i), v);
			check(v, {1'b1, rst[i]});
		end
		foreach (rows[i]) begin
			h.wr(rows[i][21:16], rows[i][15:8]);
			h.rd(rows[i][21:16], v);
			check(v, {1'b1, rows[i][7:0]});
		end
		h.wr(OFS_PAGE_SELECT_CONTROL, 8'h82);
		tick(2);
		check(reg_addr_q, 6'h25);
		h.wr(OFS_PAGE_SELECT_CONTROL, 8'h02);
		tick(2);
		check({det_q, reg_addr_q}, 7'h6A);
		h.wr(OFS_TEST_SIGNAL_SELECT_ONE, 8'h03);
		h.wr(OFS_PROBE_BUS_AND_SEQUENCE_CONTROL, 8'h15);
		tick(2);
		check(sig_q, 1'b1);
		check(bus_q, 5'h15);
		h.wr(OFS_PIN_OUTPUT_VALUE, 8'h9F);
		for (int i = 0; i < 5; i++) begin
			@(posedge clk_sys);
			host_if <= hm[i];
			h.wr(OFS_PIN_DRIVER_ENABLE, pe[i]);
			tick(2);
			check(d_oe_q, oe[i]);
			check(aux_q, pe[i][7]);
		end
		h.rd(OFS_PIN_OUTPUT_VALUE, v);
		check(v, 9'h1D5);
		@(posedge clk_sys);
		host_if <= HOST_SPI;
		probe_data <= 8'h01;
		h.wr(OFS_PROBE_BUS_AND_SEQUENCE_CONTROL, 8'h80);
		tick(2);
		check(d_oe_q, 7'h7F);
		check(d_out_q, 7'h10);
		@(posedge clk_sys);
		probe_data <= 8'h6A;
		tick(2);
		check(d_out_q, 7'h4B);
		h.wr(OFS_PROBE_BUS_AND_SEQUENCE_CONTROL, 8'h00);
		h.wr(OFS_PIN_DRIVER_ENABLE, 8'h00);
		h.wr(OFS_TEST_SIGNAL_SELECT_ONE, 8'h08);
		tick(2);
		check(d_oe_q, 7'h02);
		for (int k = 0; k < 3; k++) begin
			run = 3'b001 << k;
			for (int s = 0; s < 4; s++) begin
				h.wr(OFS_TEST_SIGNAL_SELECT_ONE, 8'(s << 4));
				tick(8);
				seen = 1'b0;
				repeat (40) begin
					tick(1);
					seen |= sc_q;
				end
				check(seen, s == k + 1);
			end
		end
		h.pulse();
		tick(2);
		check(act_q, 1'b0);
		foreach (pm[i]) begin
			// Reference bits from the tap recurrence, seed of all ones.
			for (int n = 0; n < 32; n++) begin
				ref_b[n] = (n < 9 + 6 * i) ? 1'b1 :
					ref_b[n - 9 - 6 * i] ^ ref_b[n - 5 - 9 * i];
			end
			h.seq(pm[i]);
			tick(2);
			check(act_q, 1'b1);
			ones = 0;
			for (int j = 0; j < 30; j++) begin
				tick(1);
				ones += int'(bit_q === 1'b1);
				check(bit_q, ref_b[j + 2]);
			end
			check(ones > 0 && ones < 30, 1'b1);
			h.wr(OFS_PROBE_BUS_AND_SEQUENCE_CONTROL, 8'h00);
			tick(2);
			check(act_q, 1'b0);
		end
		// Reset in mid-run, with a sequence sending and the page in use.
		h.wr(OFS_PAGE_SELECT_CONTROL, 8'h81);
		h.seq(pm[0]);
		@(posedge clk_sys);
		reset <= 1'b1;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		h.rd(OFS_PIN_DRIVER_ENABLE, v);
		check(v, {1'b1, RST_PIN_DRIVER_ENABLE});
		check(act_q, 1'b0);
		check(aux_q, 1'b1);
		check({det_q, reg_addr_q}, 7'h6A);
		give_verdict();
	end
endmodule
